// >>> psl_sensor_link.sv
// Purpose: link timing of a current-modulated satellite sensor
// Assumes: sync pin from outside, sensor samples on clk domain
// Notes: frame content beyond start bits, data and parity is elsewhere
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module psl_sensor_link
    import psl_pkg::*;
#(
    parameter int INIT1_LEN = INIT1_TICKS,
    parameter int BLANK_LEN = BLANK_TICKS,
    parameter int PM_TIMEOUT_LEN = PM_TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // link
    input wire logic syncPin,
    output logic modCurrent,
    output logic chainSwitchGate,
    // sensor core
    input wire logic signed [9:0] sampleIn,
    input wire logic signed [9:0] offsetRaw,
    // command decoder
    input wire logic setAddrReq,
    input wire logic progInputSeen,
    input wire logic otpWriteReq,
    output logic cmdDiscard,
    output logic otpProgram
);
    ////////////////////////////////////////////////////////////////////
    // oscillator tick: fractional divider gives an exact 4 MHz average
    logic [7:0] acc_reg;
    logic tick_reg;
    wire [7:0] accSum = acc_reg + 8'(OSC_KHZ / 1000);
    wire accWrap = accSum >= 8'(CLK_KHZ / 1000);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= accWrap ? accSum - 8'(CLK_KHZ / 1000) : accSum;
            tick_reg <= accWrap;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sync pin synchroniser and rising-edge detect from the second and third stages
    logic syncS1_reg, syncS2_reg, syncS3_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            syncS1_reg <= 1'b0;
            syncS2_reg <= 1'b0;
            syncS3_reg <= 1'b0;
        end else begin
            syncS1_reg <= syncPin;
            syncS2_reg <= syncS1_reg;
            syncS3_reg <= syncS2_reg;
        end
    end
    wire syncEdge = syncS2_reg && !syncS3_reg;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [9:0] ctrl_reg;
    logic [9:0] slotField_reg;
    logic [31:0] rd_reg;
    logic timeout_reg;
    wire asyncMode = ctrl_reg[C_ASYNC];
    wire highRate = ctrl_reg[C_HIGHRATE];
    wire tenBit = ctrl_reg[C_TENBIT];
    wire daisy = ctrl_reg[C_DAISY];
    wire progSlot = ctrl_reg[C_PROGSLOT];
    wire dblRate = ctrl_reg[C_DOUBLE];
    wire progMode = ctrl_reg[C_PROGMODE];
    wire [1:0] chainPos = ctrl_reg[C_CHAINPOS +: 2];

    // response delay after a sync, in oscillator periods
    function automatic logic [10:0] slotTicks(input logic dc, input logic ps,
                                              input logic [1:0] pos, input logic [9:0] fld);
        logic [10:0] t;
        t = 11'(SLOT_DEFAULT);
        if (ps) t = 11'(SLOT_DEFAULT);
        else if (dc && pos == 2'h2) t = 11'(SLOT_DC2);
        else if (dc && pos == 2'h3) t = 11'(SLOT_DC3);
        else if (!dc && fld != 10'h000) t = {fld, 1'b0};
        return t;
    endfunction

    // phase 2 and 3 lengths, counted in syncs or frames
    function automatic logic [9:0] phaseLen(input logic p3, input logic as, input logic tb);
        logic [9:0] n;
        n = 10'(INIT3_SYNC);
        if (p3) n = as ? 10'(INIT3_ASYNC) : 10'(INIT3_SYNC);
        else if (as) n = tb ? 10'(INIT2_ASYNC10) : 10'(INIT2_ASYNC8);
        else n = tb ? 10'(INIT2_SYNC10) : 10'(INIT2_SYNC8);
        return n;
    endfunction

    wire [10:0] curSlot = slotTicks(daisy, progSlot, chainPos, slotField_reg);
    wire [10:0] setupTicks = dblRate ? 11'(SETUP_DOUBLE) : 11'(SETUP_SYNC);

    ////////////////////////////////////////////////////////////////////
    // interpolation delay line, one stage per tick
    logic signed [9:0] pipe_reg [INTERP_STAGES];
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pipe_reg[0] <= 10'sh000;
        end else if (tick_reg) begin
            pipe_reg[0] <= sampleIn;
        end
    end
    genvar gi;
    generate
        for (gi = 1; gi < INTERP_STAGES; gi++) begin : gPipe
            always_ff @(posedge clk) begin
                if (!nrst) pipe_reg[gi] <= 10'sh000;
                else if (tick_reg) pipe_reg[gi] <= pipe_reg[gi-1];
            end
        end
    endgenerate
    wire signed [9:0] interpOut = pipe_reg[INTERP_STAGES-1];

    // output range limit in ten-bit mode
    wire signed [9:0] limHi = 10'(RANGE_LIM);
    wire signed [9:0] limLo = -10'(RANGE_LIM);
    wire signed [9:0] clipped = !tenBit ? interpOut :
        (interpOut > limHi) ? limHi : (interpOut < limLo) ? limLo : interpOut;

    ////////////////////////////////////////////////////////////////////
    // phase sequencer, slot countdown and sample latch
    psl_phase_t phase_reg;
    logic [19:0] phaseCnt_reg;
    logic [10:0] down_reg;
    logic armed_reg;
    logic signed [9:0] latched_reg;
    logic txStart_reg;
    logic [17:0] blank_reg;
    logic addrPend_reg;
    logic gate_reg;
    wire blanking = blank_reg != 18'h00000;
    wire syncOk = syncEdge && !blanking && !asyncMode && phase_reg != PH_INIT1;
    wire frameStart = tick_reg && armed_reg && down_reg == 11'h001;
    wire phaseStep = asyncMode ? frameStart : syncOk;
    wire [9:0] needLen = phaseLen(phase_reg == PH_INIT3, asyncMode, tenBit);
    wire txDone;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_reg <= PH_INIT1;
            phaseCnt_reg <= 20'h00000;
        end else if (phase_reg == PH_INIT1) begin
            if (tick_reg) begin
                phaseCnt_reg <= phaseCnt_reg + 20'h00001;
                if (phaseCnt_reg == 20'(INIT1_LEN - 1)) begin
                    phase_reg <= PH_INIT2;
                    phaseCnt_reg <= 20'h00000;
                end
            end
        end else if (phase_reg != PH_RUN && phaseStep) begin
            phaseCnt_reg <= phaseCnt_reg + 20'h00001;
            if (phaseCnt_reg[9:0] == needLen - 10'h001) begin
                phase_reg <= (phase_reg == PH_INIT2) ? PH_INIT3 : PH_RUN;
                phaseCnt_reg <= 20'h00000;
            end
        end
    end

    // a sync loads the slot; async reloads the frame period on its own
    // previous mode, so a leftover async countdown is dropped on leaving async if no tick falls in the first cycle after the switch
    logic asyncWas_reg;
    always_ff @(posedge clk) begin
        txStart_reg <= 1'b0;
        asyncWas_reg <= nrst && asyncMode;
        if (!nrst) begin
            down_reg <= 11'h000;
            armed_reg <= 1'b0;
            latched_reg <= 10'sh000;
        end else if (syncOk) begin
            down_reg <= curSlot;
            armed_reg <= 1'b1;
            if (curSlot <= setupTicks) latched_reg <= clipped;
        end else if (asyncMode && !armed_reg && phase_reg != PH_INIT1) begin
            down_reg <= 11'(ASYNC_TICKS);
            armed_reg <= 1'b1;
        end else if (tick_reg && armed_reg) begin
            down_reg <= down_reg - 11'h001;
            if (down_reg == setupTicks + 11'h001) latched_reg <= clipped;
            if (down_reg == 11'h001) begin
                txStart_reg <= 1'b1;
                armed_reg <= asyncMode;
                down_reg <= 11'(ASYNC_TICKS);
            end
        end else if (!asyncMode && asyncWas_reg) begin
            armed_reg <= 1'b0;
        end
    end

    // frame: two start zeros, data lsb first, even parity
    wire [9:0] dataBits = tenBit ? latched_reg : {2'b00, latched_reg[9:2]};
    wire parity = ^dataBits;
    wire [12:0] frameWord = tenBit ? {parity, dataBits, 2'b00} : {2'b00, parity, dataBits[7:0], 2'b00};
    wire [3:0] frameLen = tenBit ? 4'hd : 4'hb;
    wire [5:0] bitLen = highRate ? 6'(BIT_HIGH_TICKS) : 6'(BIT_LOW_TICKS);
    wire [5:0] halfLen = highRate ? 6'((BIT_HIGH_TICKS + 1) / 2) : 6'(BIT_LOW_TICKS / 2);
    logic txCur;
    logic txBusy;
    logic txStartPend_reg;

    // hold the start until the next tick so the serialiser sees it
    always_ff @(posedge clk) begin
        if (!nrst) txStartPend_reg <= 1'b0;
        else if (txStart_reg) txStartPend_reg <= 1'b1;
        else if (tick_reg) txStartPend_reg <= 1'b0;
    end

    psl_manchester_tx uTx (
        .clk(clk),
        .nrst(nrst),
        .tickEn(tick_reg),
        .bitTicks(bitLen),
        .halfTicks(halfLen),
        .start(txStartPend_reg),
        .frame(frameWord),
        .nBits(frameLen),
        .curOn(txCur),
        .busy(txBusy),
        .done(txDone)
    );

    ////////////////////////////////////////////////////////////////////
    // chain addressing: gate and sync blanking after set-address reply
    always_ff @(posedge clk) begin
        if (!nrst) begin
            addrPend_reg <= 1'b0;
            gate_reg <= 1'b0;
            blank_reg <= 18'h00000;
        end else begin
            if (setAddrReq) addrPend_reg <= 1'b1;
            if (txDone && addrPend_reg) begin
                addrPend_reg <= setAddrReq;
                gate_reg <= 1'b1;
                blank_reg <= 18'(BLANK_LEN);
            end else if (tick_reg && blanking) begin
                blank_reg <= blank_reg - 18'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // programming command timeout and OTP bit timing
    logic [12:0] pmCnt_reg;
    logic pmActive_reg;
    logic discard_reg;
    logic [11:0] otpCnt_reg;
    logic otp_reg;
    wire pmExpire = tick_reg && pmActive_reg && pmCnt_reg == 13'(PM_TIMEOUT_LEN - 1);
    always_ff @(posedge clk) begin
        discard_reg <= 1'b0;
        if (!nrst || !progMode) begin
            pmCnt_reg <= 13'h0000;
            pmActive_reg <= 1'b0;
        end else if (progInputSeen) begin
            pmCnt_reg <= 13'h0000;
            pmActive_reg <= 1'b1;
        end else if (pmExpire) begin
            pmActive_reg <= 1'b0;
            discard_reg <= 1'b1;
        end else if (tick_reg && pmActive_reg) begin
            pmCnt_reg <= pmCnt_reg + 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            otpCnt_reg <= 12'h000;
            otp_reg <= 1'b0;
        end else if (otpWriteReq && !otp_reg) begin
            otpCnt_reg <= 12'(OTP_BIT_TICKS);
            otp_reg <= 1'b1;
        end else if (tick_reg && otp_reg) begin
            otpCnt_reg <= otpCnt_reg - 12'h001;
            otp_reg <= otpCnt_reg != 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // offset monitor and output flops
    logic offFault_reg;
    logic mod_reg;
    wire signed [9:0] offLim = 10'(OFFMON_LIM);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            offFault_reg <= 1'b0;
            mod_reg <= 1'b0;
        end else begin
            offFault_reg <= (offsetRaw > offLim) || (offsetRaw < -offLim);
            mod_reg <= txCur;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register port; timeout flag is write-one-to-clear, a new set wins
    wire [31:0] statusWord = {25'h0, timeout_reg, otp_reg, blanking, gate_reg,
                              offFault_reg, phase_reg};
    wire [31:0] rdMux = (regAddr == ADDR_CTRL) ? {22'h0, ctrl_reg} :
                        (regAddr == ADDR_SLOT) ? {22'h0, slotField_reg} :
                        (regAddr == ADDR_STATUS) ? statusWord :
                        (regAddr == ADDR_SAMPLE) ? {{22{latched_reg[9]}}, latched_reg} : 32'h0;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RESET;
            slotField_reg <= 10'h000;
            rd_reg <= 32'h0;
            timeout_reg <= 1'b0;
        end else begin
            if (regWrite && regAddr == ADDR_CTRL) ctrl_reg <= regWrData[9:0];
            if (regWrite && regAddr == ADDR_SLOT) slotField_reg <= regWrData[9:0];
            if (discard_reg) timeout_reg <= 1'b1;
            else if (regWrite && regAddr == ADDR_STATUS && regWrData[S_TIMEOUT]) timeout_reg <= 1'b0;
            rd_reg <= regRead ? rdMux : 32'h0;
        end
    end

    assign regRdData = rd_reg;
    assign modCurrent = mod_reg;
    assign chainSwitchGate = gate_reg;
    assign cmdDiscard = discard_reg;
    assign otpProgram = otp_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_gate_raise: assert property (@(posedge clk) disable iff (!nrst)
        txDone && addrPend_reg |=> gate_reg && blank_reg == 18'(BLANK_LEN))
        else $error("gate or blanking not started after set-address reply");
    a_sync_blanked: assert property (@(posedge clk) disable iff (!nrst)
        blanking && syncEdge && !asyncMode |=> !txStart_reg)
        else $error("sync acted on while blanked");
    a_slot_load: assert property (@(posedge clk) disable iff (!nrst)
        syncOk |=> down_reg == $past(curSlot) && armed_reg)
        else $error("slot countdown not loaded");
    a_async_reload: assert property (@(posedge clk) disable iff (!nrst)
        frameStart && asyncMode |=> down_reg == 11'(ASYNC_TICKS) && txStart_reg)
        else $error("async frame period wrong");
    a_phase1_len: assert property (@(posedge clk) disable iff (!nrst)
        $changed(phase_reg) && phase_reg == PH_INIT2 |-> $past(phaseCnt_reg) == 20'(INIT1_LEN - 1))
        else $error("phase 1 left early");
    a_range_clip: assert property (@(posedge clk) disable iff (!nrst)
        tenBit |-> clipped <= limHi && clipped >= limLo)
        else $error("ten-bit value out of range");
    a_offset_flag: assert property (@(posedge clk) disable iff (!nrst)
        offsetRaw > offLim ##1 1'b1 |-> offFault_reg)
        else $error("offset fault not flagged");
    a_pm_timeout: assert property (@(posedge clk) disable iff (!nrst)
        pmExpire && progMode && !progInputSeen |=> discard_reg && !pmActive_reg)
        else $error("command timeout missed");
    a_otp_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(otp_reg) |-> otpCnt_reg == 12'(OTP_BIT_TICKS))
        else $error("otp bit time short");
    c_chain_done: cover property (@(posedge clk) disable iff (!nrst) $rose(gate_reg));
    c_run_reached: cover property (@(posedge clk) disable iff (!nrst) phase_reg == PH_RUN);
    c_frame_sent: cover property (@(posedge clk) disable iff (!nrst) txDone);
    c_timeout: cover property (@(posedge clk) disable iff (!nrst) discard_reg);
    wire unusedBusy = txBusy;
endmodule
`default_nettype wire

// >>> psl_pkg.sv
// Purpose: shared constants for the sensor link timing block
// Assumes: 125 MHz system clock, link timing on a 4 MHz tick
// Notes: bit, programming and OTP times are kept in their own unit, tick counts derive from them
package psl_pkg;
    // clock and oscillator tick
    localparam int CLK_KHZ = 125000;
    localparam int OSC_KHZ = 4000;
    // bit times in ns and ticks
    localparam int BIT_LOW_NS = 8000;
    localparam int BIT_HIGH_NS = 5250;
    localparam int BIT_LOW_TICKS = BIT_LOW_NS * OSC_KHZ / 1000000;
    localparam int BIT_HIGH_TICKS = BIT_HIGH_NS * OSC_KHZ / 1000000;
    // frame and slot timing, in oscillator periods
    localparam int ASYNC_TICKS = 912;
    localparam int SLOT_DEFAULT = 186;
    localparam int SLOT_DC2 = 768;
    localparam int SLOT_DC3 = 1400;
    localparam int SETUP_SYNC = 52;
    localparam int SETUP_DOUBLE = 54;
    localparam int INTERP_STAGES = 64;
    // init and chain timing
    localparam int INIT1_TICKS = 532000;
    localparam int INIT2_SYNC10 = 256;
    localparam int INIT2_SYNC8 = 288;
    localparam int INIT2_ASYNC10 = 512;
    localparam int INIT2_ASYNC8 = 576;
    localparam int INIT3_SYNC = 2;
    localparam int INIT3_ASYNC = 19;
    localparam int BLANK_TICKS = 200000;
    // programming mode
    localparam int PM_PERIOD_US = 500;
    localparam int PM_TIMEOUT_TICKS = 4 * PM_PERIOD_US * OSC_KHZ / 1000;
    localparam int OTP_BIT_US = 512;
    localparam int OTP_BIT_TICKS = (OTP_BIT_US * OSC_KHZ + 999) / 1000;
    // output limits
    localparam int RANGE_LIM = 480;
    localparam int OFFMON_LIM = 66;
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLOT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SAMPLE = 8'h0c;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    // control and status bit positions
    localparam int C_ASYNC = 0;
    localparam int C_HIGHRATE = 1;
    localparam int C_TENBIT = 2;
    localparam int C_DAISY = 3;
    localparam int C_PROGSLOT = 4;
    localparam int C_DOUBLE = 5;
    localparam int C_PROGMODE = 6;
    localparam int C_CHAINPOS = 7;
    localparam int S_TIMEOUT = 6;
    typedef enum logic [1:0] {PH_INIT1, PH_INIT2, PH_INIT3, PH_RUN} psl_phase_t;
endpackage

// >>> psl_manchester_tx.sv
// Purpose: serialises one frame as Manchester current modulation
// Assumes: tickEn is a one-cycle 4 MHz enable, frame sent lsb first
// Notes: a start while busy is ignored
`timescale 1ns/10ps
`default_nettype none
module psl_manchester_tx (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // timing
    input wire logic tickEn,
    input wire logic [5:0] bitTicks,
    input wire logic [5:0] halfTicks,
    // frame
    input wire logic start,
    input wire logic [12:0] frame,
    input wire logic [3:0] nBits,
    // line side
    output logic curOn,
    output logic busy,
    output logic done
);
    logic busy_reg;
    logic [12:0] shift_reg;
    logic [3:0] left_reg;
    logic [5:0] cnt_reg;
    logic cur_reg;
    logic done_reg;
    wire bitEnd = (cnt_reg == bitTicks - 6'h01);
    wire firstHalf = (cnt_reg < halfTicks);

    ////////////////////////////////////////////////////////////////////
    // bit counter; the first half of a zero carries current
    always_ff @(posedge clk) begin
        done_reg <= 1'b0;
        if (!nrst) begin
            busy_reg <= 1'b0;
            shift_reg <= 13'h0000;
            left_reg <= 4'h0;
            cnt_reg <= 6'h00;
            cur_reg <= 1'b0;
        end else if (tickEn) begin
            if (!busy_reg) begin
                cur_reg <= 1'b0;
                if (start) begin
                    busy_reg <= 1'b1;
                    shift_reg <= frame;
                    left_reg <= nBits;
                    cnt_reg <= 6'h00;
                    cur_reg <= !frame[0];
                end
            end else if (bitEnd) begin
                cnt_reg <= 6'h00;
                shift_reg <= {1'b0, shift_reg[12:1]};
                left_reg <= left_reg - 4'h1;
                if (left_reg == 4'h1) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    cur_reg <= 1'b0;
                end else begin
                    cur_reg <= !shift_reg[1];
                end
            end else begin
                cnt_reg <= cnt_reg + 6'h01;
                // mid-bit transition at the half count
                cur_reg <= (cnt_reg + 6'h01 < halfTicks) ? !shift_reg[0] : shift_reg[0];
            end
        end
    end

    assign curOn = cur_reg;
    assign busy = busy_reg;
    assign done = done_reg;

    a_half_split: assert property (@(posedge clk) disable iff (!nrst)
        tickEn && busy_reg && !bitEnd && (cnt_reg + 6'h01 == halfTicks)
        |=> cur_reg == shift_reg[0])
        else $error("mid-bit transition misplaced");
    wire unusedHalf = firstHalf;
endmodule
`default_nettype wire

// >>> psl_ecu_model.sv
// Purpose: control unit model that sends sync pulses on the line
// Assumes: period is given in clk cycles, 62500 is 500 us at 125 MHz
// Notes: line idles low between pulses, pulse is 8 clk wide
`timescale 1ns/10ps
`default_nettype none
module psl_ecu_model #(
    parameter int PERIOD = 62500
) (
    // clock
    input wire logic clk,
    // control from the bench
    input wire logic enable,
    // line
    output logic syncPin
);
    int cnt = 0;
    // first pulse right at enable, so the bench controls when syncs begin
    always @(posedge clk) begin
        cnt <= (!enable || cnt == PERIOD - 1) ? 0 : cnt + 1;
        syncPin <= enable && cnt < 8;
    end
endmodule
`default_nettype wire

// >>> psl_sensor_link_test.sv
// Purpose: self-checking bench for the sensor link timing block
// Assumes: short init, blank and timeout lengths via parameters
// Notes: one tick is 31.25 clk, so windows allow one tick of slack; bit-shape windows, tick to tick, allow 6 clk
`timescale 1ns/10ps
`default_nettype none
module psl_sensor_link_test import psl_pkg::*;;
    logic clk = 0, nrst = 0, regWrite = 0, regRead = 0, syncEn = 0;
    logic setAddrReq = 0, progInputSeen = 0, otpWriteReq = 0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, d;
    logic signed [9:0] offsetRaw = 10'sh000;
    logic signed [9:0] sampleIn = 10'sh1f4; // above the ten-bit limit on purpose
    logic signed [9:0] ofs [4] = '{10'sh042, 10'sh3be, 10'sh043, 10'sh3bd};
    logic syncPin, modCurrent, chainSwitchGate, cmdDiscard, otpProgram;
    int fails = 0, tests_run = 0, cyc = 0, n, m;
    // clock; sample input tied, its path is not timed here
    always #4 clk = ~clk;
    psl_sensor_link #(.INIT1_LEN(50), .BLANK_LEN(40), .PM_TIMEOUT_LEN(30)) dut_u (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .syncPin(syncPin), .modCurrent(modCurrent), .chainSwitchGate(chainSwitchGate),
        .sampleIn(sampleIn), .offsetRaw(offsetRaw), .setAddrReq(setAddrReq),
        .progInputSeen(progInputSeen), .otpWriteReq(otpWriteReq),
        .cmdDiscard(cmdDiscard), .otpProgram(otpProgram));
    psl_ecu_model ecu_u (.clk(clk), .enable(syncEn), .syncPin(syncPin));
    ////////////////////////////////////////////////////////////////////////////
    // bus tasks and checks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic inr(input int v, input int lo, input int hi);
        tests_run++;
        if (v < lo || v > hi) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        d = regRdData;
    endtask
    // bounded wait on one output, counted in clk cycles
    task automatic waitOn(input int s, input logic v, output int k);
        k = 0;
        while (k < 40000 && (s == 0 ? modCurrent : s == 1 ? chainSwitchGate :
               s == 2 ? cmdDiscard : otpProgram) !== v) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard, well above the 79k cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            fails++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_CTRL); chk(d, 32'h0);
        rd(8'h10); chk(d, 32'h0);
        rd(ADDR_STATUS); chk(d & 32'h3, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            offsetRaw <= ofs[i];
            repeat (3) @(posedge clk);
            rd(ADDR_STATUS); chk(d & 32'h4, i > 1 ? 32'h4 : 32'h0);
        end
        repeat (1700) @(posedge clk);
        rd(ADDR_STATUS); chk(d & 32'h3, 32'h1);
        // default slot, then bit shape, then chain gate and blanking
        @(posedge clk);
        setAddrReq <= 1'b1;
        syncEn <= 1'b1;
        @(posedge clk);
        setAddrReq <= 1'b0;
        waitOn(0, 1'b1, n); inr(n, 5805, 5860);
        @(posedge clk);
        syncEn <= 1'b0;
        waitOn(0, 1'b0, m); inr(m, 494, 506);
        waitOn(0, 1'b1, n); inr(n + m, 994, 1006);
        waitOn(1, 1'b1, n); inr(n, 1, 37500);
        rd(ADDR_STATUS); chk(d & 32'h18, 32'h18);
        // programming command timeout and sticky flag
        wr(ADDR_CTRL, 32'h40);
        @(posedge clk);
        progInputSeen <= 1'b1;
        @(posedge clk);
        progInputSeen <= 1'b0;
        waitOn(2, 1'b1, n); inr(n, 900, 970);
        rd(ADDR_STATUS); chk(d & 32'h40, 32'h40);
        wr(ADDR_STATUS, 32'h40);
        rd(ADDR_STATUS); chk(d & 32'h40, 32'h0);
        // otp bit programming starts at once and holds
        @(posedge clk);
        otpWriteReq <= 1'b1;
        @(posedge clk);
        otpWriteReq <= 1'b0;
        waitOn(3, 1'b1, n); inr(n, 0, 2);
        repeat (2000) @(negedge clk);
        chk(otpProgram, 1'b1);
        // free-running ten-bit frames, spacing taken start to start
        wr(ADDR_CTRL, 32'h5);
        waitOn(0, 1'b1, n);
        repeat (20000) @(negedge clk);
        waitOn(0, 1'b1, n); inr(n, 8460, 8540);
        rd(ADDR_SAMPLE); chk(d, 32'h1e0);
        summarize();
    end
endmodule
`default_nettype wire
